// ---- logic/fault_watchdog.sv ----
/*
 Fault watchdog: control register, countdown, halt handling and the
 open-drain chip reset pin, reached over a classic Wishbone slave.
 Assumes haltExec and extWake are same-clock pulses from the core, the
 option bits are static levels, and resetPinIn comes from the pad.
*/
// Notes on behaviour
// - Count decrements once per 12288 machine cycles.
// - Armed 40h to 3Fh drives reset pulse.
// - After reset register reads 7Fh, disarmed.
// - Arm bit set by software, cleared by reset.
// - Arm set with top clear resets at once.
// - Hardware option makes watchdog always armed.
// - Wait mode leaves counting unchanged.
// - Halt with reset option while armed resets.
// - Halt freezes counter and blocks expiry resets.
// - After interrupt wake, wait 4096 clocks first.
// - Control at 24h: arm bit7, count 6:0.
`timescale 1ns/1ps
`include "wdg_consts.svh"

module fault_watchdog
    import wdg_pkg::*;
#(
    parameter int PRESC_CYC = `WDG_PRESC_CYC,
    parameter int RST_PULSE_CYC = `WDG_RST_PULSE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire wdgOpt_t options,
    input wire logic haltExec,
    input wire logic extWake,
    input wire logic resetPinIn,
    output logic resetPinOut,
    output logic resetPinOe
);
    // ==========================================
    // Address decoding

    function automatic logic hitWord(input logic [7:0] adr, input logic [7:0] off);
        hitWord = adr[7:2] == off[7:2];
    endfunction : hitWord

    logic ack_r;
    logic [31:0] dat_r;
    wdgCtrl_t ctrl_r;
    wdgCtrl_t ctrl_nxt;
    powerState_t state_r;
    powerState_t state_nxt;
    logic [12:0] wakeCnt_r;
    logic [2:0] pinSync_r;
    logic pinLevel_r;
    logic pulseActive;
    logic countTick;

    wire wbReq = cyc_i & stb_i;
    wire ctrlHit = hitWord(adr_i, `WDG_CTRL_OFFSET);
    wire statHit = hitWord(adr_i, `WDG_STAT_OFFSET);
    wire wrCtrl = wbReq & ack_r & we_i & sel_i[0] & ctrlHit;
    wire rdTake = wbReq & ~ack_r & ~we_i;

    // ==========================================
    // Wishbone slave

    wire [31:0] statWord = {
        28'h0000000,
        state_r == ST_WAKE,
        state_r == ST_HALT,
        pinLevel_r,
        pulseActive
    };
    wire [31:0] rdNxt = ctrlHit ? {24'h000000, ctrl_r} :
                        statHit ? statWord : 32'h00000000;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= wbReq & ~ack_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dat_r <= 32'h00000000;
        end else if (rdTake) begin
            dat_r <= rdNxt;
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;

    // ==========================================
    // Arming and reset causes

    wire armedEff = ctrl_r.arm | options.hwWatchdog;
    wire atExpire = ctrl_r.count == `WDG_EXPIRE_VAL;
    wire expire = armedEff & countTick & atExpire & ~wrCtrl;
    wire swReset = wrCtrl & (dat_i[`WDG_ARM_BIT] | armedEff)
                   & ~dat_i[`WDG_TOP_BIT];
    wire haltReset = haltExec & (state_r == ST_RUN)
                     & options.resetOnHalt & armedEff;
    wire fire = expire | swReset | haltReset;

    // ==========================================
    // Control register

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wrCtrl) begin
            ctrl_nxt.arm = ctrl_r.arm | dat_i[`WDG_ARM_BIT];
            ctrl_nxt.count = dat_i[6:0];
        end else if (countTick) begin
            ctrl_nxt.count = ctrl_r.count - 7'h01;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= `WDG_CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ==========================================
    // Prescaler; wait mode has no input here, so it never stalls counting

    wdg_prescaler #(
        .DIV(PRESC_CYC)
    ) u_presc (
        .clk(clk),
        .rst(rst),
        .enable(state_r == ST_RUN),
        .tick(countTick)
    );

    // ==========================================
    // Halt and wake sequencing

    wire wakeDone = wakeCnt_r == 13'(`WDG_WAKE_CYC - 1);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (haltExec && !haltReset) begin
                    state_nxt = ST_HALT;
                end
            end
            ST_HALT: begin
                if (extWake) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (wakeDone) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wakeCnt_r <= 13'h0000;
        end else if (state_r == ST_WAKE) begin
            wakeCnt_r <= wakeCnt_r + 13'h0001;
        end else begin
            wakeCnt_r <= 13'h0000;
        end
    end

    // ==========================================
    // Reset pin drive and sampling

    wdg_reset_pulse #(
        .LEN(RST_PULSE_CYC)
    ) u_pulse (
        .clk(clk),
        .rst(rst),
        .fire(fire),
        .active(pulseActive)
    );

    assign resetPinOut = 1'b0;
    assign resetPinOe = pulseActive;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinSync_r <= 3'h7;
        end else begin
            pinSync_r <= {pinSync_r[1:0], resetPinIn};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinLevel_r <= 1'b1;
        end else if (pinSync_r[1] == pinSync_r[2]) begin
            pinLevel_r <= pinSync_r[2];
        end
    end

    // ==========================================
    // Assertions

    sequence s_wr_ctrl;
        wrCtrl;
    endsequence

    sequence s_pulse_up;
        pulseActive ##1 pulseActive;
    endsequence

    property p_after_reset;
        @(posedge clk) disable iff (rst)
        $past(rst) |-> (ctrl_r == 8'h7F) && !resetPinOe;
    endproperty
    a_after_reset: assert property (p_after_reset)
        else $error("control not 7Fh or pin driven after reset");

    property p_decrement;
        @(posedge clk) disable iff (rst)
        countTick && !wrCtrl |=> ctrl_r.count == $past(ctrl_r.count) - 7'h01;
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("count did not step down on tick");

    property p_no_step;
        @(posedge clk) disable iff (rst)
        !countTick && !wrCtrl |=> $stable(ctrl_r.count);
    endproperty
    a_no_step: assert property (p_no_step)
        else $error("count changed without tick or write");

    property p_expire;
        @(posedge clk) disable iff (rst)
        armedEff && countTick && atExpire && !wrCtrl && !pulseActive
        |=> s_pulse_up;
    endproperty
    a_expire: assert property (p_expire)
        else $error("no reset pulse at 40h to 3Fh");

    property p_no_fire_disarmed;
        @(posedge clk) disable iff (rst)
        !armedEff && !pulseActive && !wrCtrl |=> !pulseActive;
    endproperty
    a_no_fire_disarmed: assert property (p_no_fire_disarmed)
        else $error("reset pulse while disarmed");

    property p_pin_drive;
        @(posedge clk) disable iff (rst)
        pulseActive |-> resetPinOe && !resetPinOut;
    endproperty
    a_pin_drive: assert property (p_pin_drive)
        else $error("reset pin not driven low in pulse");

    property p_arm_sticky;
        @(posedge clk) disable iff (rst)
        ctrl_r.arm |=> ctrl_r.arm;
    endproperty
    a_arm_sticky: assert property (p_arm_sticky)
        else $error("arm bit cleared without reset");

    property p_sw_reset;
        @(posedge clk) disable iff (rst)
        s_wr_ctrl and (dat_i[7] && !dat_i[6] && !pulseActive) |=> pulseActive;
    endproperty
    a_sw_reset: assert property (p_sw_reset)
        else $error("software reset write did not fire");

    property p_hw_armed;
        @(posedge clk) disable iff (rst)
        options.hwWatchdog |-> armedEff;
    endproperty
    a_hw_armed: assert property (p_hw_armed)
        else $error("hardware option not armed");

    property p_halt_reset;
        @(posedge clk) disable iff (rst)
        haltExec && state_r == ST_RUN && options.resetOnHalt && armedEff
        && !pulseActive |=> pulseActive && state_r == ST_RUN;
    endproperty
    a_halt_reset: assert property (p_halt_reset)
        else $error("halt with reset option did not fire");

    property p_halt_freeze;
        @(posedge clk) disable iff (rst)
        state_r != ST_RUN |-> !countTick;
    endproperty
    a_halt_freeze: assert property (p_halt_freeze)
        else $error("counting while halted or waking");

    property p_wake_hold;
        @(posedge clk) disable iff (rst)
        $rose(state_r == ST_WAKE) |-> (state_r == ST_WAKE) [*8];
    endproperty
    a_wake_hold: assert property (p_wake_hold)
        else $error("wake hold-off ended early");

    property p_wake_end;
        @(posedge clk) disable iff (rst)
        state_r == ST_WAKE && wakeDone |=> state_r == ST_RUN;
    endproperty
    a_wake_end: assert property (p_wake_end)
        else $error("wake hold-off did not end at 4096");

    property p_read_ctrl;
        @(posedge clk) disable iff (rst)
        rdTake && ctrlHit |=> ack_o && dat_o[7:0] == $past(ctrl_r);
    endproperty
    a_read_ctrl: assert property (p_read_ctrl)
        else $error("control read returned wrong data");

    property p_load;
        @(posedge clk) disable iff (rst)
        s_wr_ctrl |=> ctrl_r.count == $past(dat_i[6:0]);
    endproperty
    a_load: assert property (p_load)
        else $error("write did not load count");

    property p_ack_pulse;
        @(posedge clk) disable iff (rst)
        ack_o |=> !ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack held longer than one cycle");

endmodule : fault_watchdog

// ---- logic/wdg_consts.svh ----
/*
 Constants of the fault watchdog: register offsets, field positions,
 reset values and timing counts.
 Assumes a 250 MHz system clock that is also the machine-cycle rate.
*/
`ifndef WDG_CONSTS_SVH
`define WDG_CONSTS_SVH

// ==========================================
// Register map
`define WDG_CTRL_OFFSET 8'h24
`define WDG_STAT_OFFSET 8'h28
`define WDG_CTRL_RESET 8'h7F
`define WDG_ARM_BIT 7
`define WDG_TOP_BIT 6
`define WDG_EXPIRE_VAL 7'h40

// ==========================================
// Status register fields
`define WDG_STAT_PULSE_BIT 0
`define WDG_STAT_PIN_BIT 1
`define WDG_STAT_HALT_BIT 2
`define WDG_STAT_WAKE_BIT 3

// ==========================================
// Timing
`define WDG_CLK_PERIOD_PS 4000
`define WDG_PRESC_CYC 12288
`define WDG_RST_PULSE_US 30
`define WDG_RST_PULSE_CYC ((`WDG_RST_PULSE_US * 1000000) / `WDG_CLK_PERIOD_PS)
`define WDG_WAKE_CYC 4096

`endif

// ---- logic/wdg_pkg.sv ----
/*
 Types shared by the fault watchdog files.
 Assumes nothing of its surroundings.
*/
package wdg_pkg;

    typedef struct packed {
        logic arm;
        logic [6:0] count;
    } wdgCtrl_t;

    typedef struct packed {
        logic hwWatchdog;
        logic resetOnHalt;
    } wdgOpt_t;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_HALT,
        ST_WAKE
    } powerState_t;

endpackage : wdg_pkg

// ---- logic/wdg_prescaler.sv ----
/*
 Prescaler: one-cycle tick every DIV enabled clock cycles.
 Assumes enable comes from logic on the same clock; count holds while low.
*/
`timescale 1ns/1ps

module wdg_prescaler #(
    parameter int DIV = 12288
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    output logic tick
);
    localparam int W = $clog2(DIV);

    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    wire atLast = cnt_r == W'(DIV - 1);

    assign tick = enable & atLast;
    assign cnt_nxt = atLast ? '0 : cnt_r + W'(1);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= '0;
        end else if (enable) begin
            cnt_r <= cnt_nxt;
        end
    end

    property p_tick_spaced;
        @(posedge clk) disable iff (rst)
        tick |=> !tick;
    endproperty
    a_tick_spaced: assert property (p_tick_spaced)
        else $error("prescaler ticks on two cycles in a row");

endmodule : wdg_prescaler

// ---- logic/wdg_reset_pulse.sv ----
/*
 Reset pulse stretcher: a fire pulse starts an active window of LEN cycles.
 Assumes fire is a same-clock pulse; fires during a window are ignored.
*/
`timescale 1ns/1ps

module wdg_reset_pulse #(
    parameter int LEN = 7500
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic fire,
    output logic active
);
    localparam int W = $clog2(LEN + 1);

    logic active_r;
    logic [W-1:0] cnt_r;
    wire lastCyc = cnt_r == W'(LEN - 1);

    assign active = active_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            active_r <= 1'b0;
            cnt_r <= '0;
        end else if (!active_r) begin
            active_r <= fire;
            cnt_r <= '0;
        end else begin
            active_r <= !lastCyc;
            cnt_r <= cnt_r + W'(1);
        end
    end

    property p_pulse_min;
        @(posedge clk) disable iff (rst)
        $rose(active) |-> active [*8];
    endproperty
    a_pulse_min: assert property (p_pulse_min)
        else $error("reset pulse shorter than expected");

endmodule : wdg_reset_pulse

// ---- tb/tb_top.sv ----
/*
 Self-checking bench for the fault watchdog: bus tasks and one task per scenario.
 Assumes the design files under logic/ are compiled first; short prescaler and pulse.
*/
`timescale 1ns/1ps

module tb_top;
    import wdg_pkg::*;

    localparam int PRESC = 8;
    localparam int PULSE = 10;

    logic clk;
    logic rst;
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic ack;
    logic haltExec;
    logic extWake;
    logic pinOut;
    logic pinOe;
    wdgOpt_t opts;
    int n_errors = 0;
    int n_tests = 0;

    fault_watchdog #(.PRESC_CYC(PRESC), .RST_PULSE_CYC(PULSE)) fault_watchdog_i (
        .clk(clk), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .options(opts),
        .haltExec(haltExec), .extWake(extWake), .resetPinIn(~pinOe),
        .resetPinOut(pinOut), .resetPinOe(pinOe)
    );

    // ==========================================
    // Clock, time-zero values, watchdog
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        sel = 4'hF;
        wdat = 32'h0;
        haltExec = 1'b0;
        extWake = 1'b0;
        opts = '0;
    end

    initial begin
        repeat (50000) @(posedge clk);
        n_errors++;
        final_report();
    end

    // ==========================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                      output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (n >= 50) check(0, 1, "no bus answer");
        @(posedge clk);
    endtask : wb

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask : wr

    task automatic wait_pin(input int lim, output int n);
        n = 0;
        while (pinOe !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_pin

    task automatic do_reset(input int cycles);
        rst <= 1'b1;
        repeat (cycles) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
    endtask : do_reset

    task automatic pulse(input bit wake);
        if (wake) extWake <= 1'b1;
        else haltExec <= 1'b1;
        @(posedge clk);
        extWake <= 1'b0;
        haltExec <= 1'b0;
    endtask : pulse

    // ==========================================
    // Scenarios
    task automatic t_reset_values();
        logic [31:0] q;
        wb(1'b0, 8'h24, 8'h00, q);
        check(q, 32'h7F, "control after reset");
        wr(8'h3C, 8'hC0);
        wb(1'b0, 8'h3C, 8'h00, q);
        check(q, 32'h0, "unmapped read");
        wb(1'b0, 8'h24, 8'h00, q);
        check(q[7], 1'b0, "unmapped write leaves arm");
        sel <= 4'hE;
        wr(8'h24, 8'hC0);
        sel <= 4'hF;
        wb(1'b0, 8'h24, 8'h00, q);
        check(q[7], 1'b0, "write without byte select ignored");
        $display("test reset_values done");
    endtask : t_reset_values

    task automatic t_rate_disarmed();
        logic [31:0] q;
        int n;
        wr(8'h24, 8'h7F);
        repeat (79) @(posedge clk);
        wb(1'b0, 8'h24, 8'h00, q);
        check(q[7:0] inside {8'h74, 8'h75, 8'h76}, 1'b1, "decrement rate");
        wr(8'h24, 8'h41);
        wait_pin(6 * PRESC, n);
        check(n, 6 * PRESC, "disarmed expiry stays quiet");
        $display("test rate_disarmed done");
    endtask : t_rate_disarmed

    task automatic t_expire();
        logic [31:0] q;
        int n;
        wr(8'h24, 8'hC5);
        repeat (4) begin
            wr(8'h24, 8'hC3);
            wait_pin(2 * PRESC, n);
            check(n, 2 * PRESC, "reloads keep pin quiet");
        end
        wr(8'h24, 8'h45);
        wb(1'b0, 8'h24, 8'h00, q);
        check(q[7], 1'b1, "arm survives clear write");
        check(q[6:0] inside {7'h45, 7'h44}, 1'b1, "count loaded");
        wait_pin(8 * PRESC + 10, n);
        check(pinOe, 1'b1, "expiry drives pin");
        check(pinOut, 1'b0, "pin pulled low");
        n = 0;
        while (pinOe === 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check(n, PULSE, "pulse length");
        do_reset(2);
        wb(1'b0, 8'h24, 8'h00, q);
        check(q, 32'h7F, "control after chip reset");
        $display("test expire done");
    endtask : t_expire

    task automatic t_soft_reset();
        int n;
        wr(8'h24, 8'h80);
        wait_pin(3, n);
        check(pinOe, 1'b1, "software reset");
        do_reset(2);
        $display("test soft_reset done");
    endtask : t_soft_reset

    task automatic t_hw_option();
        int n;
        opts.hwWatchdog <= 1'b1;
        do_reset(2);
        wr(8'h24, 8'h41);
        wait_pin(3 * PRESC + 10, n);
        check(pinOe, 1'b1, "hardware option arms");
        opts.hwWatchdog <= 1'b0;
        do_reset(2);
        $display("test hw_option done");
    endtask : t_hw_option

    task automatic t_halt();
        logic [31:0] q;
        int n;
        wr(8'h24, 8'hC1);
        pulse(1'b0);
        wait_pin(200, n);
        check(n, 200, "halt blocks reset");
        wb(1'b0, 8'h24, 8'h00, q);
        check(q[7:0] inside {8'hC1, 8'hC0}, 1'b1, "halt freezes count");
        wb(1'b0, 8'h28, 8'h00, q);
        check(q, 32'h00000006, "status while halted");
        pulse(1'b1);
        wb(1'b0, 8'h28, 8'h00, q);
        check(q, 32'h0000000A, "status in wake hold-off");
        wait_pin(4000, n);
        check(n, 4000, "wake hold-off");
        wait_pin(200, n);
        check(pinOe, 1'b1, "count resumes after wake");
        do_reset(2);
        $display("test halt done");
    endtask : t_halt

    task automatic t_halt_reset();
        int n;
        opts.resetOnHalt <= 1'b1;
        do_reset(2);
        wr(8'h24, 8'hFF);
        pulse(1'b0);
        wait_pin(3, n);
        check(pinOe, 1'b1, "halt resets when armed");
        opts.resetOnHalt <= 1'b0;
        do_reset(2);
        $display("test halt_reset done");
    endtask : t_halt_reset

    // ==========================================
    // Verdict and main sequence
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_reset_values();
        t_rate_disarmed();
        t_expire();
        t_soft_reset();
        t_hw_option();
        t_halt();
        t_halt_reset();
        final_report();
    end
endmodule : tb_top
